// ==== hdl/fhc_host.sv ====
// Purpose: Host controller driving an asynchronous parallel flash
// Assumes: APB slave for software; flash pins asynchronous to clk
// Notes: Software writes commands as plain bus writes, one per request
`timescale 1ns/1ps
module fhc_host (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fhc_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chipSelect0,
   output logic chipSelect1,
   output logic chipSelect2,
   output logic outputDriveN,
   output logic writeStrobeN,
   output logic resetPowerdownN,
   output logic byteWidthSelectN,
   output logic programEnableHigh,
   output logic [fhc_pkg::ADDR_W-1:0] flashAddr,
   output logic [fhc_pkg::DQ_W-1:0] dqOut,
   output logic dqOe,
   input wire logic [fhc_pkg::DQ_W-1:0] dqIn,
   input wire logic statusOutput
);
   import fhc_pkg::*;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      fhc_state_t fsm;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] wdata;
      logic [DQ_W-1:0] rdata;
      logic isWrite;
      logic x16;
      logic pen;
      logic ready;
      logic [2:0] cs;
      logic oeN;
      logic weN;
      logic rpN;
      logic dqOe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [CNT_W-1:0] lowCnt;
      logic [CNT_W-1:0] hiCnt;
   } fhc_host_t;
   localparam fhc_host_t RST_ST = '{
      fsm: S_RST_GO, addr: '0, wdata: '0, rdata: '0, isWrite: 1'b0,
      x16: CTRL_X16_RST, pen: 1'b0, ready: 1'b0, cs: CS_IDLE,
      oeN: 1'b1, weN: 1'b1, rpN: 1'b0, dqOe: 1'b0, prdata: '0,
      pready: 1'b0, pslverr: 1'b0, lowCnt: '0, hiCnt: '0};
   fhc_host_t s;
   fhc_host_t n;
   fhc_timer_if tif ();
   logic [DQ_W:0] pinSync;
   logic [DQ_W-1:0] dqSync;
   logic devBusy;
   logic busy;
   logic hit;
   logic [31:0] rd;
   logic commit;
   // ------------------------------------------------------------
   // Pin synchronisers and pin timer
   // ------------------------------------------------------------
   fhc_sync2 #(.W(DQ_W + 1)) u_sync (
      .clk(clk),
      .reset(reset),
      .d({statusOutput, dqIn}),
      .q(pinSync)
   );
   fhc_timer u_timer (
      .clk(clk),
      .reset(reset),
      .t(tif.tmr)
   );
   assign dqSync = pinSync[DQ_W-1:0];
   // Status output low means an internal algorithm is running
   assign devBusy = !pinSync[DQ_W];
   assign busy = (s.fsm != S_IDLE);
   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   always_comb
   begin
      hit = 1'b1;
      rd = '0;
      unique case (paddr)
         REG_CTRL:
         begin
            rd[CTRL_WRITE] = s.isWrite;
            rd[CTRL_X16] = s.x16;
            rd[CTRL_PEN] = s.pen;
         end
         REG_ADDR: rd[ADDR_W-1:0] = s.addr;
         REG_WDATA: rd[DQ_W-1:0] = s.wdata;
         REG_RDATA: rd[DQ_W-1:0] = s.rdata;
         REG_STATUS:
         begin
            rd[STAT_BUSY] = busy;
            rd[STAT_READY] = s.ready;
            rd[STAT_DEVBUSY] = devBusy;
         end
         default: hit = 1'b0;
      endcase
   end
   // Writes land at the edge where the master samples pready high
   assign commit = s.pready && psel && penable && pwrite && hit && !busy;
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      n = s;
      tif.load = 1'b0;
      tif.count = '0;
      n.lowCnt = s.rpN ? '0 : ((s.lowCnt == '1) ? s.lowCnt : s.lowCnt + CNT_W'(1));
      n.hiCnt = !s.rpN ? '0 : ((s.hiCnt == '1) ? s.hiCnt : s.hiCnt + CNT_W'(1));
      unique case (s.fsm)
         S_RST_GO:
         begin
            // Deselect and float everything while the device powers down
            n.rpN = 1'b0;
            n.cs = CS_IDLE;
            n.oeN = 1'b1;
            n.weN = 1'b1;
            n.dqOe = 1'b0;
            tif.load = 1'b1;
            tif.count = T_RST_PULSE;
            n.fsm = S_RST_LOW;
         end
         S_RST_LOW:
         begin
            if (tif.done)
            begin
               n.rpN = 1'b1;
               tif.load = 1'b1;
               // Covers both wake-up and reset-to-write recovery
               tif.count = T_RST_WAIT;
               n.fsm = S_RST_WAIT;
            end
         end
         S_RST_WAIT:
         begin
            if (tif.done)
            begin
               n.ready = 1'b1;
               n.fsm = S_IDLE;
            end
         end
         S_IDLE:
         begin
         end
         S_RD_WAIT:
         begin
            if (tif.done)
            begin
               n.rdata = s.x16 ? dqSync : {8'h00, dqSync[7:0]};
               n.oeN = 1'b1;
               n.cs = CS_IDLE;
               n.fsm = S_IDLE;
            end
         end
         S_WR_SETUP:
         begin
            if (tif.done)
            begin
               n.weN = 1'b0;
               tif.load = 1'b1;
               tif.count = T_WR_PULSE;
               n.fsm = S_WR_PULSE;
            end
         end
         S_WR_PULSE:
         begin
            if (tif.done)
            begin
               // Strobe rises first so the device latches before deselect
               n.weN = 1'b1;
               tif.load = 1'b1;
               tif.count = T_WR_HOLD;
               n.fsm = S_WR_HOLD;
            end
         end
         S_WR_HOLD:
         begin
            if (tif.done)
            begin
               n.cs = CS_IDLE;
               n.dqOe = 1'b0;
               n.fsm = S_IDLE;
            end
         end
      endcase
      // APB: first access edge loads read data, second one completes
      if (s.pready)
      begin
         n.pready = 1'b0;
         n.pslverr = 1'b0;
      end
      else if (psel && penable)
      begin
         n.pready = 1'b1;
         n.pslverr = !hit;
         n.prdata = rd;
      end
      if (commit)
      begin
         unique case (paddr)
            REG_ADDR: n.addr = pwdata[ADDR_W-1:0];
            REG_WDATA: n.wdata = pwdata[DQ_W-1:0];
            REG_CTRL:
            begin
               n.isWrite = pwdata[CTRL_WRITE];
               n.x16 = pwdata[CTRL_X16];
               n.pen = pwdata[CTRL_PEN];
               if (pwdata[CTRL_RESET])
               begin
                  n.ready = 1'b0;
                  n.fsm = S_RST_GO;
               end
               else if (pwdata[CTRL_GO] && s.ready)
               begin
                  n.cs = CS_SEL;
                  tif.load = 1'b1;
                  if (pwdata[CTRL_WRITE])
                  begin
                     n.dqOe = 1'b1;
                     tif.count = T_WR_SETUP;
                     n.fsm = S_WR_SETUP;
                  end
                  else
                  begin
                     // Strobe stays high for the whole read
                     n.oeN = 1'b0;
                     tif.count = T_READ;
                     n.fsm = S_RD_WAIT;
                  end
               end
            end
            default:
            begin
            end
         endcase
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         // Same reset as the host pulls the flash reset pin low
         s <= RST_ST;
      end
      else
      begin
         s <= n;
      end
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign chipSelect0 = s.cs[0];
   assign chipSelect1 = s.cs[1];
   assign chipSelect2 = s.cs[2];
   assign outputDriveN = s.oeN;
   assign writeStrobeN = s.weN;
   assign resetPowerdownN = s.rpN;
   assign byteWidthSelectN = s.x16;
   assign programEnableHigh = s.pen;
   assign flashAddr = s.addr;
   assign dqOut = s.wdata;
   assign dqOe = s.dqOe;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_read_strobe_high;
      @(posedge clk) disable iff (reset)
      !s.oeN |-> s.weN && !s.dqOe && (s.cs == CS_SEL);
   endproperty
   a_read_strobe_high: assert property (p_read_strobe_high)
      else $error("strobe low or data driven during read");
   property p_reset_pulse;
      @(posedge clk) disable iff (reset)
      $rose(s.rpN) |-> s.lowCnt >= T_RST_PULSE;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse)
      else $error("reset pulse shorter than minimum");
   property p_reset_to_write;
      @(posedge clk) disable iff (reset)
      $fell(s.weN) |-> s.rpN && (s.hiCnt >= T_TO_WRITE);
   endproperty
   a_reset_to_write: assert property (p_reset_to_write)
      else $error("command written too soon after reset");
   property p_system_reset;
      @(posedge clk) disable iff (reset)
      $fell(reset) |-> !s.rpN && (s.cs == CS_IDLE) ##1 !s.rpN;
   endproperty
   a_system_reset: assert property (p_system_reset)
      else $error("flash reset not held with system reset");
   property p_write_addr_stable;
      @(posedge clk) disable iff (reset)
      !s.weN |=> $stable(s.addr) && $stable(s.wdata) && s.dqOe && (s.cs == CS_SEL);
   endproperty
   a_write_addr_stable: assert property (p_write_addr_stable)
      else $error("command address or data moved during write");
endmodule : fhc_host

// ==== hdl/fhc_pkg.sv ====
// Purpose: Shared constants and types of the flash host controller
// Assumes: 200 MHz clock; flash pins driven straight from flip-flops
// Notes: Pin times are plain defaults; tune them to the fitted part
package fhc_pkg;
   // ------------------------------------------------------------
   // Clock and pin timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int RST_PULSE_NS = 100;
   localparam int RST_WAKE_NS = 100;
   localparam int RST_TO_WRITE_NS = 100;
   localparam int READ_ACCESS_NS = 120;
   localparam int WR_SETUP_NS = 20;
   localparam int WR_PULSE_NS = 60;
   localparam int WR_HOLD_NS = 20;
   localparam int SYNC_STAGES = 2;
   localparam int RST_WAIT_NS = (RST_WAKE_NS > RST_TO_WRITE_NS) ? RST_WAKE_NS : RST_TO_WRITE_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] T_RST_PULSE = CNT_W'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] T_RST_WAIT = CNT_W'((RST_WAIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] T_TO_WRITE = CNT_W'((RST_TO_WRITE_NS + CLK_NS - 1) / CLK_NS);
   // Synchroniser delay added so sampled data is really settled
   localparam logic [CNT_W-1:0] T_READ =
      CNT_W'((READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
   localparam logic [CNT_W-1:0] T_WR_SETUP = CNT_W'((WR_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] T_WR_PULSE = CNT_W'((WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] T_WR_HOLD = CNT_W'((WR_HOLD_NS + CLK_NS - 1) / CLK_NS);
   // ------------------------------------------------------------
   // Widths, pin levels, register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int DQ_W = 16;
   localparam int PADDR_W = 8;
   localparam logic [2:0] CS_IDLE = 3'h1;
   localparam logic [2:0] CS_SEL = 3'h0;
   localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [PADDR_W-1:0] REG_ADDR = 8'h04;
   localparam logic [PADDR_W-1:0] REG_WDATA = 8'h08;
   localparam logic [PADDR_W-1:0] REG_RDATA = 8'h0C;
   localparam logic [PADDR_W-1:0] REG_STATUS = 8'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_X16 = 2;
   localparam int CTRL_RESET = 3;
   localparam int CTRL_PEN = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_DEVBUSY = 2;
   localparam logic CTRL_X16_RST = 1'h1;
   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      S_RST_GO = 8'h01,
      S_RST_LOW = 8'h02,
      S_RST_WAIT = 8'h04,
      S_IDLE = 8'h08,
      S_RD_WAIT = 8'h10,
      S_WR_SETUP = 8'h20,
      S_WR_PULSE = 8'h40,
      S_WR_HOLD = 8'h80
   } fhc_state_t;
endpackage : fhc_pkg

// ==== hdl/fhc_sync2.sv ====
// Purpose: Two-stage synchroniser for flash pins read back by the host
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module fhc_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import fhc_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fhc_sync_t;
   fhc_sync_t s;
   fhc_sync_t n;

   always_comb
   begin
      n.s1 = d;
      n.s2 = s.s1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign q = s.s2;
endmodule : fhc_sync2

// ==== hdl/fhc_timer.sv ====
// Purpose: Down counter that times every flash pin phase
// Assumes: Loaded counts are at least one
// Notes: Done stays high once zero is reached until the next load
`timescale 1ns/1ps
module fhc_timer (
   input wire logic clk,
   input wire logic reset,
   fhc_timer_if.tmr t
);
   import fhc_pkg::*;
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } fhc_tmr_t;
   fhc_tmr_t s;
   fhc_tmr_t n;

   always_comb
   begin
      n = s;
      if (t.load)
      begin
         n.cnt = t.count;
      end
      else if (s.cnt != '0)
      begin
         n.cnt = s.cnt - CNT_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign t.done = (s.cnt == '0);
endmodule : fhc_timer

// ==== hdl/fhc_timer_if.sv ====
// Purpose: Load and done handshake between sequencer and pin timer
// Assumes: Both ends on the same clock
// Notes: Count is loaded in the cycle load is high
`timescale 1ns/1ps
interface fhc_timer_if;
   import fhc_pkg::*;
   logic load;
   logic [CNT_W-1:0] count;
   logic done;
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface : fhc_timer_if

// ==== test/fhc_flash_model.sv ====
// Purpose: Behavioural parallel flash device facing the host controller
// Assumes: Pins change only after clk edges, so sampling on clk sees every edge
// Notes: Counts host timing faults; floating data lines toggle, status pin is pulled up
`timescale 1ns/1ps
module fhc_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
   parameter int RST_MIN = 20,
   parameter int TO_WRITE = 20,
   parameter int WAKE = 20,
   parameter int PROG_CYCLES = 100
) (
   input wire logic clk,
   input wire logic chipSelect0,
   input wire logic chipSelect1,
   input wire logic chipSelect2,
   input wire logic outputDriveN,
   input wire logic writeStrobeN,
   input wire logic resetPowerdownN,
   input wire logic byteWidthSelectN,
   input wire logic programEnableHigh,
   input wire logic [23:0] flashAddr,
   input wire logic [15:0] dqOut,
   input wire logic dqOe,
   output logic [15:0] dqBus,
   output logic statusOutput,
   output logic [7:0] faults
);
   logic sel;
   logic drive;
   logic [15:0] word;
   logic [15:0] rdVal;
   logic [15:0] mem [0:255];
   logic [15:0] lastBus = 16'h0000;
   logic [7:0] lastIdx = 8'h00;
   logic [1:0] mode = 2'h0;
   logic prevWe = 1'b1;
   logic prevSel = 1'b0;
   logic prevRp = 1'b0;
   logic prog = 1'b0;
   logic abortLow = 1'b0;
   int busyCnt = 0;
   int lowCnt = 0;
   int sinceRise = 0;
   initial faults = 8'h00;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h5A00 | 16'(i);
   assign sel = ({chipSelect2, chipSelect1, chipSelect0} == 3'h0) ||
      (chipSelect2 && !(chipSelect1 && chipSelect0));
   assign word = mem[flashAddr[8:1]];
   always_comb
   begin
      case (mode)
         2'h1: rdVal = {8'h00, flashAddr[1] ? PART_CODE : MAKER_CODE};
         2'h2: rdVal = {8'h00, (busyCnt != 0) ? 8'h00 : 8'h80};
         // Query data stands in as a small address-dependent pattern
         2'h3: rdVal = {8'h00, 8'hA0 | 8'(flashAddr[3:1])};
         default: rdVal = byteWidthSelectN ? word :
            {8'h00, flashAddr[0] ? word[15:8] : word[7:0]};
      endcase
      // Upper lines are unused in byte mode, so they float
      if (!byteWidthSelectN) rdVal[15:8] = ~lastBus[15:8];
   end
   assign drive = sel && resetPowerdownN && !outputDriveN && writeStrobeN &&
      (sinceRise >= WAKE);
   assign dqBus = dqOe ? dqOut : (drive ? rdVal : ~lastBus);
   assign statusOutput = !((busyCnt != 0) || abortLow);
   always @(posedge clk)
   begin
      lastBus <= dqBus;
      prevWe <= writeStrobeN;
      prevSel <= sel;
      prevRp <= resetPowerdownN;
      if (busyCnt != 0) busyCnt <= busyCnt - 1;
      // Unknown reset pin before the host leaves reset counts as reset
      if (resetPowerdownN !== 1'b1)
      begin
         lowCnt <= lowCnt + 1;
         sinceRise <= 0;
         mode <= 2'h0;
         prog <= 1'b0;
         busyCnt <= 0;
         if (busyCnt != 0) abortLow <= 1'b1;
         if (busyCnt != 0) mem[lastIdx] <= ~mem[lastIdx];
      end
      else
      begin
         faults <= faults + 8'(!prevRp && lowCnt < RST_MIN)
            + 8'(sel && !writeStrobeN && prevWe && sinceRise < TO_WRITE)
            + 8'(sel && !outputDriveN && !writeStrobeN);
         lowCnt <= 0;
         abortLow <= 1'b0;
         if (sinceRise < 1000) sinceRise <= sinceRise + 1;
         if (prevSel && !prevWe && (writeStrobeN || !sel))
         begin
            if (prog)
            begin
               prog <= 1'b0;
               mode <= 2'h2;
               if (programEnableHigh)
               begin
                  mem[flashAddr[8:1]] <= dqBus;
                  lastIdx <= flashAddr[8:1];
                  busyCnt <= PROG_CYCLES;
               end
            end
            else
               case (dqBus[7:0])
                  8'hFF: mode <= 2'h0;
                  8'h90: mode <= 2'h1;
                  8'h98: mode <= 2'h3;
                  8'h70: mode <= 2'h2;
                  8'h40, 8'h10: prog <= 1'b1;
                  default: ;
               endcase
         end
      end
   end
endmodule : fhc_flash_model

// ==== test/test_fhc_host.sv ====
// Purpose: Self-checking bench of the flash host controller over APB
// Assumes: Flash model stands on the pins; words of the array start as 5A00h plus index
// Notes: Only x16 programming is exercised
`timescale 1ns/1ps
`define CHK(g, x) check(32'(g), 32'(x))
module test_fhc_host;
   import fhc_pkg::*;
   localparam logic [31:0] RD16 = 32'h5, RD8 = 32'h1, WR16 = 32'h7, WRPEN = 32'h17;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, e;
   logic chipSelect0, chipSelect1, chipSelect2, outputDriveN, writeStrobeN;
   logic resetPowerdownN, byteWidthSelectN, programEnableHigh, dqOe, statusOutput;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [ADDR_W-1:0] flashAddr;
   logic [DQ_W-1:0] dqOut, dqIn;
   logic [7:0] faults;
   int failures = 0, testsRun = 0, cycles = 0;
   fhc_host dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chipSelect0(chipSelect0), .chipSelect1(chipSelect1), .chipSelect2(chipSelect2),
      .outputDriveN(outputDriveN), .writeStrobeN(writeStrobeN),
      .resetPowerdownN(resetPowerdownN), .byteWidthSelectN(byteWidthSelectN),
      .programEnableHigh(programEnableHigh), .flashAddr(flashAddr), .dqOut(dqOut),
      .dqOe(dqOe), .dqIn(dqIn), .statusOutput(statusOutput));
   fhc_flash_model flash (.clk(clk), .chipSelect0(chipSelect0), .chipSelect1(chipSelect1),
      .chipSelect2(chipSelect2), .outputDriveN(outputDriveN), .writeStrobeN(writeStrobeN),
      .resetPowerdownN(resetPowerdownN), .byteWidthSelectN(byteWidthSelectN),
      .programEnableHigh(programEnableHigh), .flashAddr(flashAddr), .dqOut(dqOut),
      .dqOe(dqOe), .dqBus(dqIn), .statusOutput(statusOutput), .faults(faults));
   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] g, input logic [31:0] x);
      testsRun++;
      if (g !== x)
      begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask : check
   task automatic finishTest;
      $display("Comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finishTest
   // Entered just after a rising edge; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rq, output logic re);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rq;
      logic re;
      apb(1'b1, a, d, rq, re);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] rq);
      logic re;
      apb(1'b0, a, 32'h0, rq, re);
   endtask : rd
   task automatic waitStat(input int b, input logic v);
      logic [31:0] rq;
      int n;
      n = 0;
      rd(REG_STATUS, rq);
      while (rq[b] !== v && n < 300)
      begin
         rd(REG_STATUS, rq);
         n++;
      end
      `CHK(rq[b], v);
   endtask : waitStat
   task automatic op(input logic [23:0] a, input logic [15:0] d, input logic [31:0] c);
      wr(REG_ADDR, 32'(a));
      wr(REG_WDATA, 32'(d));
      wr(REG_CTRL, c);
      waitStat(STAT_BUSY, 1'b0);
   endtask : op
   task automatic rdv(input logic [23:0] a, input logic [31:0] c, input logic [31:0] x);
      logic [31:0] rq;
      op(a, 16'h0000, c);
      rd(REG_RDATA, rq);
      `CHK(rq, x);
   endtask : rdv
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         finishTest;
      end
   end
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      `CHK({chipSelect2, chipSelect1, chipSelect0, resetPowerdownN, outputDriveN,
         writeStrobeN, dqOe}, {CS_IDLE, 4'h6});
      reset <= 1'b0;
      @(posedge clk);
      waitStat(STAT_READY, 1'b1);
      rd(REG_CTRL, q);
      `CHK(q, 32'h4);
      apb(1'b0, 8'h14, 32'h0, q, e);
      `CHK(e, 1'b1);
      for (int i = 0; i < 4; i++) rdv(24'(2 * i), RD16, 32'h5A00 + i);
      for (int j = 4; j < 6; j++) rdv(24'(j), RD8, j[0] ? 32'h5A : 32'h02);
      op(24'h6, 16'h0040, WR16);
      op(24'h6, 16'h1234, WR16);
      op(24'h0, 16'h00FF, WR16);
      rdv(24'h6, RD16, 32'h5A03);
      op(24'h6, 16'h0040, WRPEN);
      op(24'h6, 16'h1234, WRPEN);
      rd(REG_STATUS, q);
      `CHK(q[STAT_DEVBUSY], 1'b1);
      waitStat(STAT_DEVBUSY, 1'b0);
      op(24'h0, 16'h0070, WR16);
      rdv(24'h0, RD16, 32'h80);
      op(24'h0, 16'h00FF, WR16);
      rdv(24'h6, RD16, 32'h1234);
      op(24'h0, 16'h0090, WR16);
      for (int k = 0; k < 4; k++) rdv(24'(k), RD8, k[1] ? 32'hC3 : 32'h3C);
      rdv(24'h2, RD16, 32'h00C3);
      op(24'h0, 16'h0098, WR16);
      rdv(24'h4, RD16, 32'hA2);
      wr(REG_CTRL, 32'hC);
      waitStat(STAT_READY, 1'b0);
      waitStat(STAT_READY, 1'b1);
      rdv(24'h0, RD16, 32'h5A00);
      `CHK(faults, 8'h00);
      finishTest;
   end
endmodule : test_fhc_host
